// [tb/icad_fetch_model.sv]
// fetch stage and memory access unit model feeding the check block
`timescale 1ns/1ps

module icad_fetch_model
  import icad_pkg::*;
(
  input wire logic clk_i,
  output logic insn_valid_o,
  output logic [15:0] insn_o,
  output logic [31:0] insn_pc_o,
  output logic mem_req_o,
  output icad_size_e mem_size_o,
  output logic [31:0] mem_addr_o
);
  // idle code, pc and address lines show the inverse of the last value so stale codes are never reused
  initial begin
    insn_valid_o = 1'b0;
    insn_o = 16'h0000;
    insn_pc_o = 32'h0000_0000;
    mem_req_o = 1'b0;
    mem_size_o = ICAD_SZ_BYTE;
    mem_addr_o = 32'h0000_0000;
  end

  // offer one code, or two on consecutive cycles, then go idle
  task automatic fetch(input logic [15:0] c0, input logic [15:0] c1,
                       input logic [31:0] pc, input bit two);
    @(posedge clk_i);
    insn_valid_o <= 1'b1;
    insn_o <= c0;
    insn_pc_o <= pc;
    if (two) begin
      @(posedge clk_i);
      insn_o <= c1;
      insn_pc_o <= pc + 32'h0000_0002;
    end
    @(posedge clk_i);
    insn_valid_o <= 1'b0;
    insn_o <= ~insn_o;
    insn_pc_o <= ~insn_pc_o;
  endtask : fetch

  // one memory access check request
  task automatic access(input icad_size_e sz, input logic [31:0] a);
    @(posedge clk_i);
    mem_req_o <= 1'b1;
    mem_size_o <= sz;
    mem_addr_o <= a;
    @(posedge clk_i);
    mem_req_o <= 1'b0;
    mem_addr_o <= ~a;
  endtask : access
endmodule : icad_fetch_model

// [tb/test_insn_check_and_add_decode.sv]
// self-checking bench of the instruction check and add decode block
`timescale 1ns/1ps

module test_insn_check_and_add_decode import icad_pkg::*;;
  logic clk, resetn, reg_wr, reg_rd, insn_valid, mem_req, addr_err, chk_valid, wb_en;
  logic insn_ready, irq, prev_v;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, insn_pc, mem_addr, wb_data, pc_rel, psw;
  logic [15:0] insn;
  logic [3:0] wb_idx;
  icad_size_e mem_size;
  icad_exc_e exc;
  int bad_count, n_tests, errs, base;
  logic [70:0] res_q[$];
  logic [15:0] slot_codes [6] = '{16'h8900, 16'h8B00, 16'hA000, 16'hC300, 16'hFFFF, 16'h402B};
  logic [15:0] bad_codes [4] = '{16'hFFFF, 16'h0000, 16'h0001, 16'hF123};
  icad_size_e sz_tab [6] = '{ICAD_SZ_WORD, ICAD_SZ_WORD, ICAD_SZ_LONG, ICAD_SZ_LONG,
                             ICAD_SZ_BYTE, ICAD_SZ_LONG};
  logic [31:0] ad_tab [6] = '{32'h1001, 32'h1002, 32'h1002, 32'h1004, 32'h1003, 32'h1001};
  int err_tab [6] = '{1, 0, 1, 0, 0, 1};

  icad_core #(.HAS_REPEAT(1'b1), .HAS_EXT_SPACE(1'b0)) icad_core_i (
    .clk_i(clk), .resetn_i(resetn), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .insn_valid_i(insn_valid), .insn_i(insn), .insn_pc_i(insn_pc),
    .insn_ready_o(insn_ready), .mem_req_i(mem_req), .mem_size_i(mem_size),
    .mem_addr_i(mem_addr), .addr_err_o(addr_err), .chk_valid_o(chk_valid), .exc_o(exc),
    .wb_en_o(wb_en), .wb_idx_o(wb_idx), .wb_data_o(wb_data), .pc_rel_o(pc_rel),
    .psw_o(psw), .irq_o(irq));

  icad_fetch_model icad_fetch_model_i (
    .clk_i(clk), .insn_valid_o(insn_valid), .insn_o(insn), .insn_pc_o(insn_pc),
    .mem_req_o(mem_req), .mem_size_o(mem_size), .mem_addr_o(mem_addr));

  // ---------------------------------------------------------------------------
  // clock, checking tasks and monitor
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // one result per taken instruction, exactly one cycle later; ready never drops
  always @(posedge clk) begin
    prev_v <= insn_valid;
    if (resetn) begin
      check("result pulse", {31'h0, prev_v}, {31'h0, chk_valid});
      check("ready", 32'h1, {31'h0, insn_ready});
    end
    if (addr_err === 1'b1) errs <= errs + 1;
    if (chk_valid === 1'b1) res_q.push_back({exc, wb_en, wb_idx, wb_data, pc_rel});
  end

  task automatic chk_insn(input icad_exc_e e, input logic w, input logic [3:0] i,
                          input logic [31:0] d, input logic [31:0] p);
    logic [70:0] r;
    if (res_q.size() == 0) begin
      check("result count", 32'h1, 32'h0);
      return;
    end
    r = res_q.pop_front();
    check("exc", 32'(e), 32'(r[70:69]));
    check("wb_en", {31'h0, w}, {31'h0, r[68]});
    if (w) check("wb_idx", 32'(i), 32'(r[67:64]));
    if (w) check("wb_data", d, r[63:32]);
    check("pc_rel", p, r[31:0]);
  endtask : chk_insn

  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic one(input logic [15:0] c, input logic [31:0] pc, input icad_exc_e e,
                     input logic w, input logic [3:0] i, input logic [31:0] d);
    icad_fetch_model_i.fetch(c, 16'h0000, pc, 1'b0);
    settle();
    chk_insn(e, w, i, d, pc + ICAD_PC_AHEAD);
  endtask : one

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(nm, e, reg_rdata);
  endtask : rd_chk

  // ---------------------------------------------------------------------------
  // test sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    #20000;
    bad_count++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(ICAD_OFS_PSW, ICAD_PSW_RESET, "psw reset");
    rd_chk(8'h14, 32'h0, "unmapped");
    wr(ICAD_OFS_PSW, 32'hFFFF_FFFF);
    rd_chk(ICAD_OFS_PSW, ICAD_PSW_WMASK, "psw fields");
    wr(ICAD_OFS_PSW, 32'h0000_0003);
    wr(8'h44, 32'h7FFF_FFFF);
    wr(8'h48, 32'h0000_0001);
    wr(8'h4C, 32'h0000_0001);
    icad_fetch_model_i.fetch(16'h312C, 16'h73FE, 32'h1000, 1'b1);
    settle();
    chk_insn(ICAD_EXC_NONE, 1'b1, 4'h1, 32'h8000_0000, 32'h1004);
    chk_insn(ICAD_EXC_NONE, 1'b1, 4'h3, 32'hFFFF_FFFF, 32'h1006);
    icad_fetch_model_i.fetch(16'h312C, 16'h312C, 32'h2000, 1'b1);
    settle();
    chk_insn(ICAD_EXC_NONE, 1'b1, 4'h1, 32'h8000_0001, 32'h2004);
    chk_insn(ICAD_EXC_NONE, 1'b1, 4'h1, 32'h8000_0002, 32'h2006);
    one(16'h7201, 32'h3000, ICAD_EXC_NONE, 1'b1, 4'h2, 32'h0000_0002);
    rd_chk(8'h44, 32'h8000_0002, "r1");
    rd_chk(ICAD_OFS_PSW, 32'h0000_0003, "test flag");
    check("psw port", 32'h0000_0003, psw);
    foreach (bad_codes[k]) one(bad_codes[k], 32'h3100, ICAD_EXC_ILLEGAL, 1'b0, 4'h0, 32'h0);
    wr(ICAD_OFS_PSW, 32'h0000_0001);
    one(16'h002B, 32'h3200, ICAD_EXC_ILLEGAL, 1'b0, 4'h0, 32'h0);
    one(16'h411E, 32'h3202, ICAD_EXC_NONE, 1'b0, 4'h0, 32'h0);
    wr(ICAD_OFS_PSW, 32'h0000_0003);
    foreach (slot_codes[k]) begin
      icad_fetch_model_i.fetch(16'hA000, slot_codes[k], 32'h4000, 1'b1);
      settle();
      chk_insn(ICAD_EXC_NONE, 1'b0, 4'h0, 32'h0, 32'h4004);
      chk_insn(ICAD_EXC_SLOT, 1'b0, 4'h0, 32'h0, 32'h4006);
    end
    rd_chk(ICAD_OFS_EVT_STATUS, 32'h6, "events");
    check("irq masked", 32'h0, {31'h0, irq});
    wr(ICAD_OFS_EVT_MASK, 32'h4);
    settle();
    check("irq raised", 32'h1, {31'h0, irq});
    wr(ICAD_OFS_EVT_STATUS, 32'h4);
    settle();
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(ICAD_OFS_EVT_STATUS, 32'hF);
    wr(ICAD_OFS_RPT_START, 32'h0000_0100);
    wr(ICAD_OFS_RPT_END, 32'h0000_010C);
    wr(ICAD_OFS_PSW, 32'h0001_0003);
    one(16'h8B00, 32'h010A, ICAD_EXC_ILLEGAL, 1'b0, 4'h0, 32'h0);
    one(16'h410E, 32'h010A, ICAD_EXC_ILLEGAL, 1'b0, 4'h0, 32'h0);
    one(16'h8B00, 32'h0100, ICAD_EXC_NONE, 1'b0, 4'h0, 32'h0);
    one(16'h312C, 32'h010A, ICAD_EXC_NONE, 1'b1, 4'h1, 32'h8000_0004);
    wr(ICAD_OFS_PSW, 32'h0000_0003);
    rd_chk(ICAD_OFS_EVT_STATUS, 32'h8, "loop event");
    wr(ICAD_OFS_EVT_MASK, 32'h1);
    foreach (sz_tab[k]) begin
      base = errs;
      icad_fetch_model_i.access(sz_tab[k], ad_tab[k]);
      settle();
      check("addr err", 32'(err_tab[k]), 32'(errs - base));
    end
    check("irq addr", 32'h1, {31'h0, irq});
    rd_chk(ICAD_OFS_EVT_STATUS, 32'h9, "addr event");
    conclude();
  end
endmodule : test_insn_check_and_add_decode

// [verilog/icad_core.sv]
// instruction legality check, alignment check and add execution
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// What this block does
// RL1: misaligned word or longword access flags error
// RL2: branch class in delay slot is illegal
// RL3: unassigned or user privileged code is illegal
// RL4: bad delay slot instruction gives slot exception
// RL5: forbidden instructions near repeat loop end trap
// RL6: program counter view is current plus four
// RL7: no wait states, one cycle latency, pitch
// RL8: result after latency, next after pitch
// RL9: register add writes destination, test unchanged
// RL10: immediate add sign extends eight bits
// RL11: status word holds flags at fixed bits
module icad_core
  import icad_pkg::*;
#(
  parameter bit HAS_REPEAT = 1'b1,
  parameter bit HAS_EXT_SPACE = 1'b0,
  parameter int ADDR_W = ICAD_ADDR_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_i,
  input wire logic [31:0] insn_pc_i,
  output logic insn_ready_o,
  input wire logic mem_req_i,
  input wire icad_size_e mem_size_i,
  input wire logic [31:0] mem_addr_i,
  output logic addr_err_o,
  output logic chk_valid_o,
  output icad_exc_e exc_o,
  output logic wb_en_o,
  output logic [3:0] wb_idx_o,
  output logic [31:0] wb_data_o,
  output logic [31:0] pc_rel_o,
  output logic [31:0] psw_o,
  output logic irq_o
);

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (ADDR_W != ICAD_ADDR_W) begin : g_bad_addr
    $error("register port address must be eight bits wide");
  end

  typedef struct packed {
    logic [31:0] psw;
    logic [31:0] rpt_start;
    logic [31:0] rpt_end;
    logic [ICAD_EVT_W-1:0] evt_status;
    logic [ICAD_EVT_W-1:0] evt_mask;
    logic in_slot;
    logic [31:0] rdata;
    logic chk_valid;
    icad_exc_e exc;
    logic addr_err;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [31:0] wb_data;
    logic [31:0] pc_view;
    logic [15:0][31:0] gpr;
  } icad_state_s;

  icad_state_s st_reg;
  icad_state_s st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  // two stages so the release is clean against clk_i
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------------------
  // pattern classification
  // ---------------------------------------------------------------------------
  logic pc_write_hit;
  logic delayed_hit;
  logic priv_hit;
  logic rpt_write_hit;
  logic undef_hit;

  icad_pattern_match #(.N(ICAD_PCW_N), .MASKS(ICAD_PCW_MASK), .MATCHES(ICAD_PCW_MATCH))
    u_pc_write (.insn_i(insn_i), .hit_o(pc_write_hit));
  icad_pattern_match #(.N(ICAD_DLY_N), .MASKS(ICAD_DLY_MASK), .MATCHES(ICAD_DLY_MATCH))
    u_delayed (.insn_i(insn_i), .hit_o(delayed_hit));
  icad_pattern_match #(.N(ICAD_PRV_N), .MASKS(ICAD_PRV_MASK), .MATCHES(ICAD_PRV_MATCH))
    u_priv (.insn_i(insn_i), .hit_o(priv_hit));
  icad_pattern_match #(.N(ICAD_RPW_N), .MASKS(ICAD_RPW_MASK), .MATCHES(ICAD_RPW_MATCH))
    u_rpt_write (.insn_i(insn_i), .hit_o(rpt_write_hit));
  icad_pattern_match #(.N(ICAD_UND_N), .MASKS(ICAD_UND_MASK), .MATCHES(ICAD_UND_MATCH))
    u_undef (.insn_i(insn_i), .hit_o(undef_hit));

  // ---------------------------------------------------------------------------
  // legality decisions
  // ---------------------------------------------------------------------------
  logic user_mode;
  logic general_invalid;
  logic rpt_active;
  logic in_loop_tail;
  logic loop_viol;
  logic add_reg_hit;
  logic add_imm_hit;
  logic [31:0] imm_sext;
  icad_exc_e exc_cmb;

  // privileged codes fail the mode check only while the supervisor flag is clear
  assign user_mode = !st_reg.psw[ICAD_PSW_SUPER];
  assign general_invalid = undef_hit // see RL3
    || (!HAS_EXT_SPACE && (insn_i[15:12] == ICAD_EXT_NIBBLE))
    || (user_mode && priv_hit);
  // loop tail covers short loops whole and the last three of longer ones
  assign rpt_active = HAS_REPEAT && (st_reg.psw[ICAD_PSW_RC_MSB:ICAD_PSW_RC_LSB] != 12'h000);
  assign in_loop_tail = (insn_pc_i >= st_reg.rpt_start) && (insn_pc_i <= st_reg.rpt_end)
    && (({1'b0, insn_pc_i} + ICAD_LOOP_TAIL) >= {1'b0, st_reg.rpt_end}); // see RL5
  assign loop_viol = rpt_active && in_loop_tail
    && (general_invalid || pc_write_hit || rpt_write_hit); // see RL5
  assign add_reg_hit = ((insn_i & ICAD_ADD_REG_MASK) == ICAD_ADD_REG_MATCH);
  assign add_imm_hit = ((insn_i & ICAD_ADD_IMM_MASK) == ICAD_ADD_IMM_MATCH);
  assign imm_sext = {{24{insn_i[7]}}, insn_i[7:0]}; // see RL10

  // slot fault outranks a plain invalid code
  always_comb begin
    exc_cmb = ICAD_EXC_NONE;
    if (st_reg.in_slot && (general_invalid || pc_write_hit)) begin
      exc_cmb = ICAD_EXC_SLOT; // see RL2 see RL4
    end else if (general_invalid || loop_viol) begin
      exc_cmb = ICAD_EXC_ILLEGAL; // see RL3 see RL5
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic [ICAD_EVT_W-1:0] evt_set;
  logic [ICAD_EVT_W-1:0] evt_clr;
  logic misaligned;

  // word needs bit 0 clear, longword needs bits 1:0 clear
  always_comb begin
    misaligned = 1'b0;
    case (mem_size_i)
      ICAD_SZ_WORD: misaligned = mem_addr_i[0]; // see RL1
      ICAD_SZ_LONG: misaligned = (mem_addr_i[1:0] != 2'h0); // see RL1
      default: misaligned = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    st_next.chk_valid = 1'b0;
    st_next.exc = ICAD_EXC_NONE;
    st_next.addr_err = mem_req_i && misaligned; // see RL1
    st_next.wb_en = 1'b0;
    evt_set = '0;
    evt_clr = '0;
    // register reads, answered in the following cycle
    if (reg_rd_i && (reg_addr_i[1:0] == 2'h0)) begin
      if (reg_addr_i[7:6] == ICAD_GPR_SEL) begin
        st_next.rdata = st_reg.gpr[reg_addr_i[5:2]];
      end else begin
        case (reg_addr_i)
          ICAD_OFS_PSW: st_next.rdata = st_reg.psw;
          ICAD_OFS_RPT_START: st_next.rdata = st_reg.rpt_start;
          ICAD_OFS_RPT_END: st_next.rdata = st_reg.rpt_end;
          ICAD_OFS_EVT_STATUS: st_next.rdata = {28'h0, st_reg.evt_status};
          ICAD_OFS_EVT_MASK: st_next.rdata = {28'h0, st_reg.evt_mask};
          default: st_next.rdata = 32'h0000_0000;
        endcase
      end
    end
    // register writes; unmapped addresses are ignored
    if (reg_wr_i && (reg_addr_i[1:0] == 2'h0)) begin
      if (reg_addr_i[7:6] == ICAD_GPR_SEL) begin
        st_next.gpr[reg_addr_i[5:2]] = reg_wdata_i;
      end else begin
        case (reg_addr_i)
          ICAD_OFS_PSW: st_next.psw = reg_wdata_i & ICAD_PSW_WMASK; // see RL11
          ICAD_OFS_RPT_START: st_next.rpt_start = reg_wdata_i;
          ICAD_OFS_RPT_END: st_next.rpt_end = reg_wdata_i;
          ICAD_OFS_EVT_STATUS: evt_clr = reg_wdata_i[ICAD_EVT_W-1:0];
          ICAD_OFS_EVT_MASK: st_next.evt_mask = reg_wdata_i[ICAD_EVT_W-1:0];
          default: st_next.evt_mask = st_reg.evt_mask;
        endcase
      end
    end
    // each accepted instruction is judged and retired in one cycle
    if (insn_valid_i) begin
      st_next.chk_valid = 1'b1; // see RL7 see RL8
      st_next.exc = exc_cmb;
      st_next.pc_view = insn_pc_i + ICAD_PC_AHEAD; // see RL6
      st_next.in_slot = delayed_hit && (exc_cmb == ICAD_EXC_NONE);
      evt_set[ICAD_EVT_SLOT] = (exc_cmb == ICAD_EXC_SLOT);
      evt_set[ICAD_EVT_ILLEGAL] = (exc_cmb == ICAD_EXC_ILLEGAL) && general_invalid;
      evt_set[ICAD_EVT_LOOP] = (exc_cmb == ICAD_EXC_ILLEGAL) && loop_viol;
      if (exc_cmb == ICAD_EXC_NONE) begin
        st_next.wb_idx = insn_i[11:8];
        if (add_reg_hit) begin
          st_next.wb_en = 1'b1;
          st_next.wb_data = st_reg.gpr[insn_i[11:8]] + st_reg.gpr[insn_i[7:4]]; // see RL9
          st_next.gpr[insn_i[11:8]] = st_next.wb_data;
        end else if (add_imm_hit) begin
          st_next.wb_en = 1'b1;
          st_next.wb_data = st_reg.gpr[insn_i[11:8]] + imm_sext; // see RL10
          st_next.gpr[insn_i[11:8]] = st_next.wb_data;
        end
      end
    end
    evt_set[ICAD_EVT_ADDR] = st_next.addr_err;
    // sticky status: a new event beats a same-cycle clear
    st_next.evt_status = (st_reg.evt_status & ~evt_clr) | evt_set;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.psw <= ICAD_PSW_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign insn_ready_o = 1'b1; // see RL7 see RL8
  assign reg_rdata_o = st_reg.rdata;
  assign addr_err_o = st_reg.addr_err;
  assign chk_valid_o = st_reg.chk_valid;
  assign exc_o = st_reg.exc;
  assign wb_en_o = st_reg.wb_en;
  assign wb_idx_o = st_reg.wb_idx;
  assign wb_data_o = st_reg.wb_data;
  assign pc_rel_o = st_reg.pc_view;
  assign psw_o = st_reg.psw;
  assign irq_o = |(st_reg.evt_status & st_reg.evt_mask);

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_add_reg_issue;
    insn_valid_i && add_reg_hit && (exc_cmb == ICAD_EXC_NONE);
  endsequence
  sequence s_add_imm_issue;
    insn_valid_i && add_imm_hit && (exc_cmb == ICAD_EXC_NONE);
  endsequence
  sequence s_delayed_issue;
    insn_valid_i && delayed_hit && (exc_cmb == ICAD_EXC_NONE);
  endsequence

  // alignment
  a_word_misalign: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL1
    mem_req_i && (mem_size_i == ICAD_SZ_WORD) && mem_addr_i[0] |=> addr_err_o)
    else $error("misaligned word access gave no address error");

  a_long_aligned_ok: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL1
    mem_req_i && (mem_size_i == ICAD_SZ_LONG) && (mem_addr_i[1:0] == 2'h0) |=> !addr_err_o)
    else $error("aligned longword access flagged");

  a_addr_err_pulse: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL1
    !mem_req_i |=> !addr_err_o)
    else $error("address error without request");

  // legality
  a_slot_branch: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL2
    s_delayed_issue ##1 (insn_valid_i && pc_write_hit) |=> (exc_o == ICAD_EXC_SLOT)
    && st_reg.evt_status[ICAD_EVT_SLOT])
    else $error("branch in delay slot not caught");

  a_invalid_code: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL3
    insn_valid_i && !st_reg.in_slot && (insn_i == 16'hFFFF) |=> (exc_o == ICAD_EXC_ILLEGAL))
    else $error("unassigned code not reported invalid");

  a_user_priv: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL3
    insn_valid_i && !st_reg.in_slot && priv_hit |=>
    ((exc_o == ICAD_EXC_ILLEGAL) == (!$past(st_reg.psw[ICAD_PSW_SUPER]) || $past(loop_viol))))
    else $error("privileged code check wrong for mode");

  a_slot_invalid: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL4
    s_delayed_issue ##1 (insn_valid_i && undef_hit) |=> (exc_o == ICAD_EXC_SLOT) && !wb_en_o)
    else $error("invalid code in delay slot not a slot exception");

  a_exc_no_write: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL4
    insn_valid_i && (exc_cmb != ICAD_EXC_NONE) |=> !wb_en_o)
    else $error("excepted instruction wrote back");

  // repeat loop
  a_loop_write: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL5
    insn_valid_i && !st_reg.in_slot && rpt_active && in_loop_tail && rpt_write_hit |=>
    (exc_o == ICAD_EXC_ILLEGAL) && st_reg.evt_status[ICAD_EVT_LOOP])
    else $error("repeat register write in loop tail not trapped");

  a_loop_outside: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL5
    insn_valid_i && !in_loop_tail && !general_invalid && !st_reg.in_slot |=>
    (exc_o == ICAD_EXC_NONE))
    else $error("loop trap outside loop tail");

  // timing, add results and status word layout
  a_pc_view: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL6
    insn_valid_i |=> chk_valid_o && (pc_rel_o == $past(insn_pc_i) + ICAD_PC_AHEAD))
    else $error("program counter view is not current plus four");

  a_pitch_one: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL7
    insn_valid_i [*2] |=> chk_valid_o && $past(chk_valid_o) && insn_ready_o)
    else $error("back to back instructions not retired every cycle");

  a_latency_one: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL8
    !insn_valid_i |=> !chk_valid_o && !wb_en_o)
    else $error("result appeared without an instruction");

  a_add_reg: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL9
    s_add_reg_issue |=> wb_en_o && (wb_idx_o == $past(insn_i[11:8]))
    && (wb_data_o == $past(st_reg.gpr[insn_i[11:8]] + st_reg.gpr[insn_i[7:4]]))
    && (psw_o[ICAD_PSW_TEST] == $past(st_reg.psw[ICAD_PSW_TEST])))
    else $error("register add result wrong");

  a_add_imm: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL10
    s_add_imm_issue |=> wb_en_o
    && (wb_data_o == $past(st_reg.gpr[insn_i[11:8]] + {{24{insn_i[7]}}, insn_i[7:0]})))
    else $error("immediate add not sign extended");

  a_psw_layout: assert property (@(posedge clk_i) disable iff (!rst_n) // see RL11
    reg_wr_i && (reg_addr_i == ICAD_OFS_PSW) |=>
    (psw_o == ($past(reg_wdata_i) & ICAD_PSW_WMASK)))
    else $error("status word write lost or unmasked");

endmodule : icad_core

// [verilog/icad_pattern_match.sv]
// mask and match comparator over a table of instruction patterns
`timescale 1ns/1ps

module icad_pattern_match #(
  parameter int N = 1,
  parameter logic [N*16-1:0] MASKS = '0,
  parameter logic [N*16-1:0] MATCHES = '0
) (
  input wire logic [15:0] insn_i,
  output logic hit_o
);

  logic [N-1:0] hits;

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (N < 1) begin : g_bad_n
    $error("pattern table must hold at least one entry");
  end

  // one comparator per table entry
  for (genvar g = 0; g < N; g++) begin : g_cmp
    assign hits[g] = ((insn_i & MASKS[g*16 +: 16]) == MATCHES[g*16 +: 16]);
  end

  assign hit_o = |hits;

endmodule : icad_pattern_match

// [verilog/icad_pkg.sv]
// shared constants and types of the instruction check and add decode block
package icad_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ---------------------------------------------------------------------------
  localparam int ICAD_ADDR_W = 8;
  localparam logic [7:0] ICAD_OFS_PSW = 8'h00;
  localparam logic [7:0] ICAD_OFS_RPT_START = 8'h04;
  localparam logic [7:0] ICAD_OFS_RPT_END = 8'h08;
  localparam logic [7:0] ICAD_OFS_EVT_STATUS = 8'h0C;
  localparam logic [7:0] ICAD_OFS_EVT_MASK = 8'h10;
  localparam logic [1:0] ICAD_GPR_SEL = 2'h1;
  // general registers sit at 0x40 + 4 * index

  // ---------------------------------------------------------------------------
  // processor status word layout
  // ---------------------------------------------------------------------------
  localparam int ICAD_PSW_TEST = 0;
  localparam int ICAD_PSW_SUPER = 1;
  localparam int ICAD_PSW_RPT_LO = 2;
  localparam int ICAD_PSW_RPT_HI = 3;
  localparam int ICAD_PSW_IMASK_LSB = 4;
  localparam int ICAD_PSW_IMASK_MSB = 7;
  localparam int ICAD_PSW_DIVQ = 8;
  localparam int ICAD_PSW_DIVM = 9;
  localparam int ICAD_PSW_RC_LSB = 16;
  localparam int ICAD_PSW_RC_MSB = 27;
  localparam logic [31:0] ICAD_PSW_WMASK = 32'h0FFF_03FF;
  localparam logic [31:0] ICAD_PSW_RESET = 32'h0000_00F2;

  // ---------------------------------------------------------------------------
  // event bits (status and mask share this layout)
  // ---------------------------------------------------------------------------
  localparam int ICAD_EVT_W = 4;
  localparam int ICAD_EVT_ADDR = 0;
  localparam int ICAD_EVT_ILLEGAL = 1;
  localparam int ICAD_EVT_SLOT = 2;
  localparam int ICAD_EVT_LOOP = 3;

  // ---------------------------------------------------------------------------
  // instruction patterns, mask and match per entry
  // ---------------------------------------------------------------------------
  localparam int ICAD_PCW_N = 13;
  localparam logic [ICAD_PCW_N*16-1:0] ICAD_PCW_MASK = {
    16'hFF00, 16'hFF00, 16'hFF00, 16'hFF00, 16'hF000, 16'hF000, 16'hF0FF,
    16'hF0FF, 16'hFFFF, 16'hFFFF, 16'hFF00, 16'hF0FF, 16'hF0FF};
  localparam logic [ICAD_PCW_N*16-1:0] ICAD_PCW_MATCH = {
    16'h8900, 16'h8B00, 16'h8D00, 16'h8F00, 16'hA000, 16'hB000, 16'h402B,
    16'h400B, 16'h000B, 16'h002B, 16'hC300, 16'h0023, 16'h0003};
  localparam int ICAD_DLY_N = 10;
  localparam logic [ICAD_DLY_N*16-1:0] ICAD_DLY_MASK = {
    16'hFF00, 16'hFF00, 16'hF000, 16'hF000, 16'hF0FF, 16'hF0FF, 16'hFFFF,
    16'hFFFF, 16'hF0FF, 16'hF0FF};
  localparam logic [ICAD_DLY_N*16-1:0] ICAD_DLY_MATCH = {
    16'h8D00, 16'h8F00, 16'hA000, 16'hB000, 16'h402B, 16'h400B, 16'h000B,
    16'h002B, 16'h0023, 16'h0003};
  localparam int ICAD_PRV_N = 6;
  localparam logic [ICAD_PRV_N*16-1:0] ICAD_PRV_MASK = {
    16'hFFFF, 16'hF0FF, 16'hF0FF, 16'hF0FF, 16'hF0FF, 16'hFFFF};
  localparam logic [ICAD_PRV_N*16-1:0] ICAD_PRV_MATCH = {
    16'h002B, 16'h400E, 16'h4007, 16'h402E, 16'h0002, 16'h001B};
  localparam int ICAD_RPW_N = 6;
  localparam logic [ICAD_RPW_N*16-1:0] ICAD_RPW_MASK = {
    16'hF0FF, 16'hFF00, 16'hFF00, 16'hFF00, 16'hF0FF, 16'hF0FF};
  localparam logic [ICAD_RPW_N*16-1:0] ICAD_RPW_MATCH = {
    16'h4014, 16'h8200, 16'h8C00, 16'h8E00, 16'h400E, 16'h4007};
  localparam int ICAD_UND_N = 2;
  localparam logic [ICAD_UND_N*16-1:0] ICAD_UND_MASK = {16'hFFFF, 16'hFFFE};
  localparam logic [ICAD_UND_N*16-1:0] ICAD_UND_MATCH = {16'hFFFF, 16'h0000};
  localparam logic [3:0] ICAD_EXT_NIBBLE = 4'hF;
  localparam logic [15:0] ICAD_ADD_REG_MASK = 16'hF00F;
  localparam logic [15:0] ICAD_ADD_REG_MATCH = 16'h300C;
  localparam logic [15:0] ICAD_ADD_IMM_MASK = 16'hF000;
  localparam logic [15:0] ICAD_ADD_IMM_MATCH = 16'h7000;

  // ---------------------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ICAD_PC_AHEAD = 32'h0000_0004;
  localparam logic [32:0] ICAD_LOOP_TAIL = 33'h0_0000_0004;

  typedef enum logic [1:0] {ICAD_SZ_BYTE, ICAD_SZ_WORD, ICAD_SZ_LONG} icad_size_e;
  typedef enum logic [1:0] {ICAD_EXC_NONE, ICAD_EXC_ILLEGAL, ICAD_EXC_SLOT} icad_exc_e;

endpackage : icad_pkg
